// file: design/apll_pkg.sv
// shared constants and types for the analog loop control register bank
package apll_pkg;

  // register byte addresses
  localparam logic [15:0] ADDR_FILTER_PUMP = 16'h00AC;
  localparam logic [15:0] ADDR_MODE_LOCK   = 16'h00AD;
  localparam logic [15:0] ADDR_VCO_A_CODE  = 16'h00AE;
  localparam logic [15:0] ADDR_VCO_B_CODE  = 16'h00AF;

  // field positions, pll_filter_pump_cfg
  localparam int CP_CUR_LSB  = 5;
  localparam int CP_CUR_MSB  = 7;
  localparam int SER_RES_LSB = 3;
  localparam int SER_RES_MSB = 4;
  localparam int PAR_CAP_LSB = 1;
  localparam int PAR_CAP_MSB = 2;
  localparam int POLE_BIT    = 0;
  // field positions, pll_mode_lock_cfg
  localparam int SYNTH_BIT   = 3;
  localparam int ACCUR_BIT   = 1;
  localparam int MANUAL_BIT  = 0;
  // field positions, lock code registers
  localparam int VCO_SEL_BIT = 5;
  localparam int CODE_LSB    = 0;
  localparam int CODE_MSB    = 4;

  // reset values per register, reserved positions zero
  localparam logic [7:0] RST_FILTER_PUMP = 8'h8B; // 100,01,01,1
  localparam logic [7:0] RST_MODE_LOCK   = 8'h02; // synth 0, accur 1, man 0
  localparam logic [7:0] RST_VCO_A_CODE  = 8'h2B; // vco 1, code 01011
  localparam logic [7:0] RST_VCO_B_CODE  = 8'h00;

  // implemented bits per register; others are reserved
  localparam logic [7:0] MASK_FILTER_PUMP = 8'hFF;
  localparam logic [7:0] MASK_MODE_LOCK   = 8'h0B;
  localparam logic [7:0] MASK_VCO_A_CODE  = 8'h3F;
  localparam logic [7:0] MASK_VCO_B_CODE  = 8'h1F;

  // analog decode values
  localparam logic [9:0]  PUMP_STEP_UA = 10'h06E;  // 110 uA per code
  localparam logic [15:0] RES_OHM_0    = 16'h014A; // 330
  localparam logic [15:0] RES_OHM_1    = 16'h0280; // 640
  localparam logic [15:0] RES_OHM_2    = 16'h04B0; // 1200
  localparam logic [15:0] RES_OHM_3    = 16'h06FE; // 1790
  localparam logic [7:0]  CAP_PF_0     = 8'h28;    // 40
  localparam logic [7:0]  CAP_PF_1     = 8'h50;    // 80
  localparam logic [7:0]  CAP_PF_2     = 8'h8C;    // 140
  localparam logic [7:0]  CAP_PF_3     = 8'hC8;    // 200
  localparam logic [15:0] POST_OHM_LO  = 16'h01F1; // 497
  localparam logic [15:0] POST_OHM_HI  = 16'h062C; // 1580
  localparam logic [7:0]  POST_CAP_PF  = 8'h28;    // 40
  localparam logic [4:0]  ACCUR_PPM_LO = 5'h01;
  localparam logic [4:0]  ACCUR_PPM_HI = 5'h10;

  // register access request from the serial management port
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } apll_req_t;

  // raw configuration fields as held in the bank
  typedef struct packed {
    logic [2:0] charge_pump_current;
    logic [1:0] filter_series_resistor;
    logic [1:0] filter_parallel_cap;
    logic       second_pole_select;
    logic       crystal_synth_mode;
    logic       lock_count_accuracy;
    logic       lock_manual_override;
    logic       manual_vco_choice;
    logic [4:0] first_vco_lock_code;
    logic [4:0] second_vco_lock_code;
  } apll_cfg_t;

  // decoded settings handed to the analog loop
  typedef struct packed {
    logic [9:0]  pump_ua;
    logic [15:0] series_ohm;
    logic [7:0]  parallel_pf;
    logic [15:0] post_ohm;
    logic [7:0]  post_pf;
    logic [4:0]  lock_ppm;
  } apll_analog_t;

endpackage

// file: design/apll_reg8.sv
// one byte-wide control register with reset value and reserved-bit mask
`timescale 1ns/1ps
`default_nettype none

module apll_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] BIT_MASK  = 8'hFF
) (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ce_in,
  input  wire logic       we_in,
  input  wire logic [7:0] wdata_in,
  output var  logic [7:0] q_out
);

  // reserved positions never store, so they always read back zero
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_out <= RESET_VAL & BIT_MASK;
    end else if (ce_in && we_in) begin
      q_out <= wdata_in & BIT_MASK;
    end
  end

endmodule

`default_nettype wire

// file: design/apll_ctrl_regs.sv
// control register bank for the first analog loop, with field decode
//
// Contract
// - a 3-bit pump current field resets to 100b, 110 uA steps to 880 uA.
// - 2-bit series resistor, reset 01b, picks 330/640/1200/1790 ohm.
// - 2-bit parallel cap, reset 01b, picks 40/80/140/200 pF.
// - second-pole bit, reset 1, picks low or high post resistor.
// - lock accuracy bit, reset 1: 0 is 1 ppm, 1 is 16 ppm.
// - lock override bit, reset 0: 0 automatic, 1 manual lock.
// - manual VCO choice bit, reset 1: 1 first VCO, 0 second VCO.
// - 5-bit manual lock code for the first VCO, reset 01011b.
// - 5-bit manual lock code for the second VCO, reset zero.
// - synth mode bit: 0 attenuates jitter, 1 runs from the crystal.
// - software writes reserved bits as zero; reads of them mean nothing.
// - fields sit in bytes PLL_FILTER_PUMP_CFG to VCO_B_LOCK_CODE: filter, mode, code, code.
`timescale 1ns/1ps
`default_nettype none

module apll_ctrl_regs (
  input  wire logic                  CLK_IN,
  input  wire logic                  RESET_N_IN,
  input  wire logic                  CE_IN,
  input  wire apll_pkg::apll_req_t   REG_REQ_IN,
  output logic                       REG_HIT_OUT,
  output logic                       REG_RVALID_OUT,
  output logic [7:0]                 REG_RDATA_OUT,
  output apll_pkg::apll_cfg_t        CFG_OUT,
  output apll_pkg::apll_analog_t     ANALOG_OUT,
  output logic                       LOCK_MANUAL_OUT,
  output logic                       ACTIVE_VCO_FIRST_OUT,
  output logic [4:0]                 ACTIVE_LOCK_CODE_OUT,
  output logic                       SYNTH_MODE_OUT
);

  logic [7:0]          filter_pump_q;
  logic [7:0]          mode_lock_q;
  logic [7:0]          vco_a_code_q;
  logic [7:0]          vco_b_code_q;
  logic                we_filter_pump;
  logic                we_mode_lock;
  logic                we_vco_a_code;
  logic                we_vco_b_code;
  logic [7:0]          rdata_d;
  apll_pkg::apll_cfg_t cfg;
  logic [9:0]          pump_code_ext;
  logic [9:0]          pump_ua_q;
  logic [15:0]         series_ohm_q;
  logic [7:0]          parallel_pf_q;
  logic [15:0]         post_ohm_q;
  logic [7:0]          post_pf_q;
  logic [4:0]          lock_ppm_q;

  // one flop set per decoded field, so no two processes share a variable
  assign ANALOG_OUT = {pump_ua_q, series_ohm_q, parallel_pf_q, post_ohm_q,
                       post_pf_q, lock_ppm_q};

  // address decode; the hit flag is a same-cycle handshake back to the port
  always_comb begin
    we_filter_pump = REG_REQ_IN.wr
      && (REG_REQ_IN.addr == apll_pkg::ADDR_FILTER_PUMP);
    we_mode_lock   = REG_REQ_IN.wr
      && (REG_REQ_IN.addr == apll_pkg::ADDR_MODE_LOCK);
    we_vco_a_code  = REG_REQ_IN.wr
      && (REG_REQ_IN.addr == apll_pkg::ADDR_VCO_A_CODE);
    we_vco_b_code  = REG_REQ_IN.wr
      && (REG_REQ_IN.addr == apll_pkg::ADDR_VCO_B_CODE);
    REG_HIT_OUT    = (REG_REQ_IN.wr || REG_REQ_IN.rd)
                     && (REG_REQ_IN.addr >= apll_pkg::ADDR_FILTER_PUMP)
                     && (REG_REQ_IN.addr <= apll_pkg::ADDR_VCO_B_CODE);
  end

  // pump, series resistor, parallel cap and second pole byte
  apll_reg8 #(
    .RESET_VAL (apll_pkg::RST_FILTER_PUMP),
    .BIT_MASK  (apll_pkg::MASK_FILTER_PUMP)
  ) u_filter_pump (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .ce_in      (CE_IN),
    .we_in      (we_filter_pump),
    .wdata_in   (REG_REQ_IN.wdata),
    .q_out      (filter_pump_q)
  );

  // synth mode, lock accuracy and lock override byte
  apll_reg8 #(
    .RESET_VAL (apll_pkg::RST_MODE_LOCK),
    .BIT_MASK  (apll_pkg::MASK_MODE_LOCK)
  ) u_mode_lock (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .ce_in      (CE_IN),
    .we_in      (we_mode_lock),
    .wdata_in   (REG_REQ_IN.wdata),
    .q_out      (mode_lock_q)
  );

  // manual vco choice and first vco lock code byte
  apll_reg8 #(
    .RESET_VAL (apll_pkg::RST_VCO_A_CODE),
    .BIT_MASK  (apll_pkg::MASK_VCO_A_CODE)
  ) u_vco_a_code (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .ce_in      (CE_IN),
    .we_in      (we_vco_a_code),
    .wdata_in   (REG_REQ_IN.wdata),
    .q_out      (vco_a_code_q)
  );

  // second vco lock code byte
  apll_reg8 #(
    .RESET_VAL (apll_pkg::RST_VCO_B_CODE),
    .BIT_MASK  (apll_pkg::MASK_VCO_B_CODE)
  ) u_vco_b_code (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .ce_in      (CE_IN),
    .we_in      (we_vco_b_code),
    .wdata_in   (REG_REQ_IN.wdata),
    .q_out      (vco_b_code_q)
  );

  // unpack the four bytes into named fields
  always_comb begin
    cfg.charge_pump_current =
      filter_pump_q[apll_pkg::CP_CUR_MSB:apll_pkg::CP_CUR_LSB];
    cfg.filter_series_resistor =
      filter_pump_q[apll_pkg::SER_RES_MSB:apll_pkg::SER_RES_LSB];
    cfg.filter_parallel_cap =
      filter_pump_q[apll_pkg::PAR_CAP_MSB:apll_pkg::PAR_CAP_LSB];
    cfg.second_pole_select   = filter_pump_q[apll_pkg::POLE_BIT];
    cfg.crystal_synth_mode   = mode_lock_q[apll_pkg::SYNTH_BIT];
    cfg.lock_count_accuracy  = mode_lock_q[apll_pkg::ACCUR_BIT];
    cfg.lock_manual_override = mode_lock_q[apll_pkg::MANUAL_BIT];
    cfg.manual_vco_choice    = vco_a_code_q[apll_pkg::VCO_SEL_BIT];
    cfg.first_vco_lock_code  =
      vco_a_code_q[apll_pkg::CODE_MSB:apll_pkg::CODE_LSB];
    cfg.second_vco_lock_code =
      vco_b_code_q[apll_pkg::CODE_MSB:apll_pkg::CODE_LSB];
    CFG_OUT = cfg;
    pump_code_ext = {7'h00, cfg.charge_pump_current};
  end

  // read mux; reserved bits come back zero because they never store
  always_comb begin
    case (REG_REQ_IN.addr)
      apll_pkg::ADDR_FILTER_PUMP: rdata_d = filter_pump_q;
      apll_pkg::ADDR_MODE_LOCK:   rdata_d = mode_lock_q;
      apll_pkg::ADDR_VCO_A_CODE:  rdata_d = vco_a_code_q;
      apll_pkg::ADDR_VCO_B_CODE:  rdata_d = vco_b_code_q;
      default:                    rdata_d = 8'h00;
    endcase
  end

  // read data held in a flop one cycle after the request
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      REG_RDATA_OUT  <= 8'h00;
      REG_RVALID_OUT <= 1'b0;
    end else if (CE_IN) begin
      REG_RVALID_OUT <= REG_REQ_IN.rd;
      if (REG_REQ_IN.rd) begin
        REG_RDATA_OUT <= rdata_d;
      end
    end
  end

  // charge pump current: equal steps, code zero is one step
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pump_ua_q <= 10'h000;
    end else if (CE_IN) begin
      pump_ua_q <=
        (pump_code_ext + 10'h001) * apll_pkg::PUMP_STEP_UA;
    end
  end

  // series resistor lookup in ascending code order
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      series_ohm_q <= 16'h0000;
    end else if (CE_IN) begin
      case (cfg.filter_series_resistor)
        2'b00:   series_ohm_q <= apll_pkg::RES_OHM_0;
        2'b01:   series_ohm_q <= apll_pkg::RES_OHM_1;
        2'b10:   series_ohm_q <= apll_pkg::RES_OHM_2;
        default: series_ohm_q <= apll_pkg::RES_OHM_3;
      endcase
    end
  end

  // parallel capacitor lookup in ascending code order
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      parallel_pf_q <= 8'h00;
    end else if (CE_IN) begin
      case (cfg.filter_parallel_cap)
        2'b00:   parallel_pf_q <= apll_pkg::CAP_PF_0;
        2'b01:   parallel_pf_q <= apll_pkg::CAP_PF_1;
        2'b10:   parallel_pf_q <= apll_pkg::CAP_PF_2;
        default: parallel_pf_q <= apll_pkg::CAP_PF_3;
      endcase
    end
  end

  // second pole: resistor moves, capacitor stays fixed
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      post_ohm_q <= 16'h0000;
      post_pf_q  <= 8'h00;
    end else if (CE_IN) begin
      post_ohm_q <= cfg.second_pole_select ?
        apll_pkg::POST_OHM_HI : apll_pkg::POST_OHM_LO;
      post_pf_q  <= apll_pkg::POST_CAP_PF;
    end
  end

  // lock detect accuracy; a large external cap needs the tight setting,
  // but that choice is left to software, not enforced here
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      lock_ppm_q <= 5'h00;
    end else if (CE_IN) begin
      lock_ppm_q <= cfg.lock_count_accuracy ?
        apll_pkg::ACCUR_PPM_HI : apll_pkg::ACCUR_PPM_LO;
    end
  end

  // manual lock steering; in automatic mode the code output rests at
  // zero so the analog side never sees a stale manual code
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      LOCK_MANUAL_OUT      <= 1'b0;
      ACTIVE_VCO_FIRST_OUT <= 1'b0;
      ACTIVE_LOCK_CODE_OUT <= 5'h00;
    end else if (CE_IN) begin
      LOCK_MANUAL_OUT      <= cfg.lock_manual_override;
      ACTIVE_VCO_FIRST_OUT <= cfg.lock_manual_override
                              && cfg.manual_vco_choice;
      if (!cfg.lock_manual_override) begin
        ACTIVE_LOCK_CODE_OUT <= 5'h00;
      end else if (cfg.manual_vco_choice) begin
        ACTIVE_LOCK_CODE_OUT <= cfg.first_vco_lock_code;
      end else begin
        ACTIVE_LOCK_CODE_OUT <= cfg.second_vco_lock_code;
      end
    end
  end

  // synth mode; forcing the digital loop to free run is software's job
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      SYNTH_MODE_OUT <= 1'b0;
    end else if (CE_IN) begin
      SYNTH_MODE_OUT <= cfg.crystal_synth_mode;
    end
  end

endmodule

`default_nettype wire

// file: test/apll_ctrl_regs_sva.sv
// concurrent checks on the analog loop control register bank ports
`timescale 1ns/1ps
`default_nettype none

module apll_ctrl_regs_sva (
  input wire logic                   CLK_IN,
  input wire logic                   RESET_N_IN,
  input wire logic                   CE_IN,
  input wire apll_pkg::apll_req_t    REG_REQ_IN,
  input wire logic                   REG_HIT_OUT,
  input wire logic                   REG_RVALID_OUT,
  input wire logic [7:0]             REG_RDATA_OUT,
  input wire apll_pkg::apll_cfg_t    CFG_OUT,
  input wire apll_pkg::apll_analog_t ANALOG_OUT,
  input wire logic                   LOCK_MANUAL_OUT,
  input wire logic                   ACTIVE_VCO_FIRST_OUT,
  input wire logic [4:0]             ACTIVE_LOCK_CODE_OUT,
  input wire logic                   SYNTH_MODE_OUT
);
  localparam logic [15:0] RES_TAB [4] = '{16'h014A, 16'h0280, 16'h04B0,
                                          16'h06FE};
  localparam logic [7:0]  CAP_TAB [4] = '{8'h28, 8'h50, 8'h8C, 8'hC8};
  logic run;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  // reset is part of the trigger: the release edge itself loads nothing
  assign run = RESET_N_IN & CE_IN;

  // write to the pump register, then one edge for the decode stage
  sequence pump_write_s;
    run && REG_REQ_IN.wr && REG_REQ_IN.addr == apll_pkg::ADDR_FILTER_PUMP;
  endsequence
  sequence read_take_s;
    run && REG_REQ_IN.rd && REG_REQ_IN.addr == apll_pkg::ADDR_MODE_LOCK;
  endsequence

  pump_decode_a: assert property (run |=> ANALOG_OUT.pump_ua ==
    (10'($past(CFG_OUT.charge_pump_current)) + 10'h001) * 10'h06E)
    else $error("pump current decode wrong");
  write_pump_a: assert property (pump_write_s ##1 run |=>
    ANALOG_OUT.pump_ua == (10'($past(REG_REQ_IN.wdata[7:5], 2)) + 10'h001)
    * 10'h06E) else $error("pump write not applied");
  series_decode_a: assert property (run |=> ANALOG_OUT.series_ohm ==
    RES_TAB[$past(CFG_OUT.filter_series_resistor)])
    else $error("series resistor decode wrong");
  cap_decode_a: assert property (run |=> ANALOG_OUT.parallel_pf ==
    CAP_TAB[$past(CFG_OUT.filter_parallel_cap)])
    else $error("parallel cap decode wrong");
  post_pole_a: assert property (run |=>
    ANALOG_OUT.post_pf == 8'h28 && ANALOG_OUT.post_ohm ==
    ($past(CFG_OUT.second_pole_select) ? 16'h062C : 16'h01F1))
    else $error("second pole decode wrong");
  lock_ppm_a: assert property (run |=> ANALOG_OUT.lock_ppm ==
    ($past(CFG_OUT.lock_count_accuracy) ? 5'h10 : 5'h01))
    else $error("lock accuracy decode wrong");
  mode_bits_a: assert property (run |=>
    LOCK_MANUAL_OUT == $past(CFG_OUT.lock_manual_override) &&
    SYNTH_MODE_OUT == $past(CFG_OUT.crystal_synth_mode))
    else $error("mode outputs wrong");
  active_code_a: assert property (run |=>
    ACTIVE_VCO_FIRST_OUT == ($past(CFG_OUT.lock_manual_override) &&
    $past(CFG_OUT.manual_vco_choice)) && ACTIVE_LOCK_CODE_OUT ==
    (!$past(CFG_OUT.lock_manual_override) ? 5'h00 :
    $past(CFG_OUT.manual_vco_choice) ? $past(CFG_OUT.first_vco_lock_code)
    : $past(CFG_OUT.second_vco_lock_code))) else $error("lock code wrong");
  read_valid_a: assert property (run |=>
    REG_RVALID_OUT == $past(REG_REQ_IN.rd)) else $error("read valid wrong");
  read_map_a: assert property (read_take_s |=>
    REG_RDATA_OUT == {4'h0, $past(CFG_OUT.crystal_synth_mode), 1'b0,
    $past(CFG_OUT.lock_count_accuracy), $past(CFG_OUT.lock_manual_override)})
    else $error("mode register read layout wrong");
  hit_decode_a: assert property (REG_HIT_OUT ==
    ((REG_REQ_IN.wr || REG_REQ_IN.rd) &&
    REG_REQ_IN.addr inside {[16'h00AC:16'h00AF]})) else $error("hit wrong");
endmodule

bind apll_ctrl_regs apll_ctrl_regs_sva apll_ctrl_regs_sva_i (.CLK_IN,
  .RESET_N_IN, .CE_IN, .REG_REQ_IN, .REG_HIT_OUT, .REG_RVALID_OUT,
  .REG_RDATA_OUT, .CFG_OUT, .ANALOG_OUT, .LOCK_MANUAL_OUT,
  .ACTIVE_VCO_FIRST_OUT, .ACTIVE_LOCK_CODE_OUT, .SYNTH_MODE_OUT);
`default_nettype wire

// file: test/apll_ctrl_regs_tb.sv
// self-checking bench for the analog loop control register bank
`timescale 1ns/1ps
`default_nettype none

module apll_ctrl_regs_tb;
  localparam logic [7:0] MSK [4] = '{8'hFF, 8'h0B, 8'h3F, 8'h1F};
  logic                   CLK_IN = 1'b0;
  logic                   RESET_N_IN = 1'b0;
  logic                   CE_IN = 1'b1;
  apll_pkg::apll_req_t    req = '0;
  logic                   rvalid, vfirst, manual, synth;
  logic [7:0]             rdata;
  logic [4:0]             code;
  apll_pkg::apll_analog_t an;
  logic [7:0]             sh [4];
  int                     n_fail = 0;
  int                     tests_run = 0;

  // free-running 100 MHz clock
  always #5 CLK_IN = ~CLK_IN;

  apll_ctrl_regs apll_ctrl_regs_i (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
    .CE_IN(CE_IN), .REG_REQ_IN(req), .REG_HIT_OUT(), .REG_RVALID_OUT(rvalid),
    .REG_RDATA_OUT(rdata), .CFG_OUT(), .ANALOG_OUT(an),
    .LOCK_MANUAL_OUT(manual), .ACTIVE_VCO_FIRST_OUT(vfirst),
    .ACTIVE_LOCK_CODE_OUT(code), .SYNTH_MODE_OUT(synth));

  // expected decoded outputs from the shadow of the four registers
  function automatic logic [70:0] exp_out(logic [7:0] f, m, a, b);
    apll_pkg::apll_analog_t e;
    logic [15:0]            res [4];
    logic [7:0]             cap [4];
    res = '{16'h014A, 16'h0280, 16'h04B0, 16'h06FE};
    cap = '{8'h28, 8'h50, 8'h8C, 8'hC8};
    e.pump_ua = (10'(f[7:5]) + 10'h001) * 10'h06E;
    e.series_ohm = res[f[4:3]];
    e.parallel_pf = cap[f[2:1]];
    e.post_ohm = f[0] ? 16'h062C : 16'h01F1;
    e.post_pf = 8'h28;
    e.lock_ppm = m[1] ? 5'h10 : 5'h01;
    return {e, m[0], m[0] & a[5],
            m[0] ? (a[5] ? a[4:0] : b[4:0]) : 5'h00, m[3]};
  endfunction

  task automatic fail(string msg);
    n_fail++;
    $display("CHECK FAILED t=%0t %s", $time, msg);
  endtask

  task automatic chk_rd(logic [7:0] exp);
    tests_run++;
    if (rvalid !== 1'b1 || rdata !== exp)
      fail($sformatf("read %h expected %h", rdata, exp));
  endtask

  task automatic chk_out(logic [70:0] exp);
    tests_run++;
    if ({an, manual, vfirst, code, synth} !== exp)
      fail("decoded outputs differ");
  endtask

  // one request cycle, then idle; two edges per call keeps drives apart
  task automatic xfer(logic w, r, logic [15:0] a, logic [7:0] d);
    @(posedge CLK_IN);
    req <= '{addr: a, wr: w, rd: r, wdata: d};
    @(posedge CLK_IN);
    req <= '0;
    #1;
  endtask

  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    xfer(1'b1, 1'b0, a, d);
    if (a inside {[16'h00AC:16'h00AF]}) sh[a[1:0]] = d;
  endtask

  task automatic rd_chk(logic [15:0] a);
    xfer(1'b0, 1'b1, a, 8'h00);
    chk_rd(a inside {[16'h00AC:16'h00AF]} ? sh[a[1:0]] : 8'h00);
  endtask

  task automatic out_chk;
    @(posedge CLK_IN);
    #1;
    chk_out(exp_out(sh[0], sh[1], sh[2], sh[3]));
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial begin
    int unsigned s;
    logic [7:0]  d;
    logic [15:0] a;
    s = $urandom(32'had0bc3a5);
    sh = '{8'h8B, 8'h02, 8'h2B, 8'h00};
    repeat (10) @(posedge CLK_IN);
    RESET_N_IN <= 1'b1;
    // defaults, plus the unmapped neighbours on each side
    for (a = 16'h00AB; a <= 16'h00B0; a++) rd_chk(a);
    out_chk();
    $display("test defaults done");
    // every pump code, every resistor and cap code, both poles
    for (int i = 0; i < 8; i++) begin
      wr_reg(16'h00AC, {3'(i), 2'(i), ~2'(i), i[0]});
      out_chk();
    end
    // manual and automatic lock, both oscillators, synth and accuracy
    for (int i = 0; i < 8; i++) begin
      wr_reg(16'h00AE, {2'b00, i[2], 5'(i * 3 + 11)});
      wr_reg(16'h00AF, {3'b000, 5'(~i)});
      wr_reg(16'h00AD, {4'h0, i[1], 1'b0, i[2], i[0]});
      out_chk();
    end
    $display("test decode done");
    // random traffic; half the writes carry a read of the old value
    repeat (40) begin
      a = 16'h00AC + 16'($urandom_range(0, 4));
      d = 8'($urandom) & MSK[a[1:0]];
      if ($urandom_range(0, 1) == 1) begin
        xfer(1'b1, 1'b1, a, d);
        chk_rd(a <= 16'h00AF ? sh[a[1:0]] : 8'h00);
      end
      wr_reg(a, d);
      rd_chk(a);
      out_chk();
    end
    $display("test random done");
    // a write with the clock enable low must not land
    @(posedge CLK_IN);
    CE_IN <= 1'b0;
    xfer(1'b1, 1'b0, 16'h00AE, sh[2] ^ 8'h15);
    @(posedge CLK_IN);
    CE_IN <= 1'b1;
    rd_chk(16'h00AE);
    $display("test enable done");
    // second reset in mid-run restores every default
    @(posedge CLK_IN);
    RESET_N_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
    RESET_N_IN <= 1'b1;
    sh = '{8'h8B, 8'h02, 8'h2B, 8'h00};
    for (a = 16'h00AC; a <= 16'h00AF; a++) rd_chk(a);
    out_chk();
    $display("test rereset done");
    tally_and_finish();
  end

  // watchdog well beyond the expected run of about four hundred cycles
  initial begin
    #100_000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
